// ---- src/psr_ctrl.sv ----
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
// ------------------------------------------------------------
// Contract
// - Glitch-free switch cannot leave the current clock unless it toggles.
// - Core reconfiguration drops lock; post-scale-only changes leave lock alone.
// - Reset drops lock; lock stays low until reacquired.
// - Phase-detector disable lets lock be lost.
// - Lock output provided; optional self-reset on loss of lock.
// - Five output clocks, each to core or external pin.
// - No output enable; reset stops all output clocks. Code also gates each output from CTRL bits 8-12.
// - Loss flags reliable only within 20% frequency difference.
// - Relock after switchover takes a finite resynchronisation time.
// - Reconfiguration-done clears only on PLL reset.
// - Only the rising request edge switches; falling edge never switches back.
// - Switch waits until the target reference toggles.
// - Selected-input indicator changes when the multiplexer completes a switch.
// ------------------------------------------------------------
module psr_ctrl #(
    parameter int LOCK_CYC = psr_pkg::LOCK_CYC_DEF,
    parameter int LOSS_CYC = psr_pkg::LOSS_CYC_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic primary_reference_clock_i,
    input wire logic secondary_reference_clock_i,
    output logic [psr_pkg::NUM_OUTS-1:0] out_clk_enable_o,
    output logic phase_frequency_detector_en_o,
    output logic downstream_reset_o,
    output psr_pkg::psr_status_s status_o
);
    import psr_pkg::*;

    // ------------------------------------------------------------
    // Reference input sampling
    // ------------------------------------------------------------
    logic [2:0] ref0_sync_ff;
    logic [2:0] ref1_sync_ff;
    logic ref0_lvl_ff;
    logic ref1_lvl_ff;
    logic ref0_edge;
    logic ref1_edge;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref0_sync_ff <= 3'h0;
            ref1_sync_ff <= 3'h0;
        end else begin
            ref0_sync_ff <= {ref0_sync_ff[1:0], primary_reference_clock_i};
            ref1_sync_ff <= {ref1_sync_ff[1:0], secondary_reference_clock_i};
        end
    end

    // Level counts only when stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref0_lvl_ff <= 1'b0;
            ref1_lvl_ff <= 1'b0;
        end else begin
            if (ref0_sync_ff[1] == ref0_sync_ff[2]) begin
                ref0_lvl_ff <= ref0_sync_ff[2];
            end
            if (ref1_sync_ff[1] == ref1_sync_ff[2]) begin
                ref1_lvl_ff <= ref1_sync_ff[2];
            end
        end
    end

    assign ref0_edge = (ref0_sync_ff[1] == ref0_sync_ff[2]) && (ref0_sync_ff[2] != ref0_lvl_ff);
    assign ref1_edge = (ref1_sync_ff[1] == ref1_sync_ff[2]) && (ref1_sync_ff[2] != ref1_lvl_ff);

    // ------------------------------------------------------------
    // Loss detection
    // ------------------------------------------------------------
    // Timeout only; frequency comparison is out of scope, so flags assume
    // the two references lie within 20% of each other
    logic [15:0] loss0_cnt_ff;
    logic [15:0] loss1_cnt_ff;
    logic loss0;
    logic loss1;

    always_ff @(posedge clk_i) begin
        if (rst_i || ref0_edge) begin
            loss0_cnt_ff <= 16'h0000;
        end else if (!loss0) begin
            loss0_cnt_ff <= loss0_cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || ref1_edge) begin
            loss1_cnt_ff <= 16'h0000;
        end else if (!loss1) begin
            loss1_cnt_ff <= loss1_cnt_ff + 16'h0001;
        end
    end

    assign loss0 = loss0_cnt_ff >= 16'(LOSS_CYC);
    assign loss1 = loss1_cnt_ff >= 16'(LOSS_CYC);

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [31:0] ctrl_ff;
    logic wr_req;
    logic rd_req;
    logic addr_ok;
    logic switch_pulse;
    logic recfg_core;
    logic recfg_any;
    logic lock_sync_ff;
    logic active_ff;
    logic recfg_done_ff;
    logic sel_busy;
    logic [15:0] lock_cnt_ff;
    logic self_reset_ff;
    logic pll_reset;

    assign addr_ok = (wb_adr_i == ADDR_CTRL) || (wb_adr_i == ADDR_STATUS) ||
                     (wb_adr_i == ADDR_RECFG) || (wb_adr_i == ADDR_LOCKCNT);
    assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !wb_err_o && addr_ok;
    assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && !wb_err_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && addr_ok;
            wb_err_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !addr_ok;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= CTRL_RESET_VAL;
        end else if (wr_req && wb_adr_i == ADDR_CTRL) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    ctrl_ff[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
                end
            end
        end
    end

    // Request edge is seen on the written bit, not its level
    logic switch_req_d_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            switch_req_d_ff <= 1'b0;
        end else begin
            switch_req_d_ff <= ctrl_ff[CTRL_SWITCH_BIT];
        end
    end
    assign switch_pulse = ctrl_ff[CTRL_SWITCH_BIT] && !switch_req_d_ff;

    assign recfg_any = wr_req && (wb_adr_i == ADDR_RECFG) && wb_sel_i[0];
    assign recfg_core = recfg_any && wb_dat_i[RC_CORE_BIT];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd_req) begin
            case (wb_adr_i)
                ADDR_CTRL: wb_dat_o <= ctrl_ff;
                ADDR_STATUS: wb_dat_o <= {26'h0, sel_busy, status_o};
                ADDR_LOCKCNT: wb_dat_o <= {16'h0, lock_cnt_ff};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------
    psr_sel_e sel_state_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_state_ff <= PSR_SEL_IDLE;
            active_ff <= 1'b0;
        end else begin
            case (sel_state_ff)
                PSR_SEL_IDLE: begin
                    if (switch_pulse) begin
                        sel_state_ff <= PSR_SEL_GATE;
                    end
                end
                // Leave old clock only on its own edge
                PSR_SEL_GATE: begin
                    if (active_ff ? ref1_edge : ref0_edge) begin
                        sel_state_ff <= PSR_SEL_WAIT_NEW;
                    end
                end
                PSR_SEL_WAIT_NEW: begin
                    if (active_ff ? ref0_edge : ref1_edge) begin
                        active_ff <= !active_ff;
                        sel_state_ff <= PSR_SEL_IDLE;
                    end
                end
                default: sel_state_ff <= PSR_SEL_IDLE;
            endcase
        end
    end
    assign sel_busy = sel_state_ff != PSR_SEL_IDLE;

    // ------------------------------------------------------------
    // Lock model
    // ------------------------------------------------------------
    logic lock_raw;
    logic cur_ref_edge;
    logic cur_loss;

    assign pll_reset = ctrl_ff[CTRL_RESET_BIT] || self_reset_ff;
    assign cur_ref_edge = active_ff ? ref1_edge : ref0_edge;
    assign cur_loss = active_ff ? loss1 : loss0;

    // Counter restarts on reset, core reconfig, loss, switch or detector off
    always_ff @(posedge clk_i) begin
        if (rst_i || pll_reset) begin
            lock_cnt_ff <= 16'h0000;
        end else if (recfg_core || cur_loss || sel_busy) begin
            lock_cnt_ff <= 16'h0000;
        end else if (!ctrl_ff[CTRL_PFD_EN_BIT]) begin
            lock_cnt_ff <= 16'h0000;
        end else if (cur_ref_edge && !lock_raw) begin
            lock_cnt_ff <= lock_cnt_ff + 16'h0001;
        end
    end
    assign lock_raw = lock_cnt_ff >= 16'(LOCK_CYC);

    // Registered so downstream release never sees a raw count glitch
    always_ff @(posedge clk_i) begin
        if (rst_i || pll_reset) begin
            lock_sync_ff <= 1'b0;
        end else begin
            lock_sync_ff <= lock_raw;
        end
    end

    // Self-reset: one pulse on loss of a held lock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            self_reset_ff <= 1'b0;
        end else begin
            self_reset_ff <= ctrl_ff[CTRL_SELF_RST_BIT] && lock_sync_ff && !lock_raw;
        end
    end

    // Hardware set wins over reset clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            recfg_done_ff <= 1'b0;
        end else if (recfg_any) begin
            recfg_done_ff <= 1'b1;
        end else if (pll_reset) begin
            recfg_done_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_clk_enable_o <= GATE_RESET_VAL;
            phase_frequency_detector_en_o <= 1'b0;
            downstream_reset_o <= 1'b1;
        end else begin
            out_clk_enable_o <= pll_reset ? GATE_RESET_VAL :
                ctrl_ff[CTRL_GATE_LSB +: NUM_OUTS];
            phase_frequency_detector_en_o <= ctrl_ff[CTRL_PFD_EN_BIT];
            downstream_reset_o <= !lock_sync_ff;
        end
    end

    assign status_o = '{lock: lock_sync_ff, active_secondary: active_ff,
                        loss_primary: loss0, loss_secondary: loss1,
                        recfg_done: recfg_done_ff};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_reset_drops_lock;
        @(posedge clk_i) disable iff (rst_i)
        pll_reset |=> !lock_sync_ff;
    endproperty
    a_reset_drops_lock: assert property (p_reset_drops_lock)
        else $error("lock high after pll reset");

    property p_reset_gates_out;
        @(posedge clk_i) disable iff (rst_i)
        pll_reset |=> out_clk_enable_o == GATE_RESET_VAL;
    endproperty
    a_reset_gates_out: assert property (p_reset_gates_out)
        else $error("output clocks running during reset");

    property p_core_recfg_drops;
        @(posedge clk_i) disable iff (rst_i)
        recfg_core |=> ##1 !lock_sync_ff;
    endproperty
    a_core_recfg_drops: assert property (p_core_recfg_drops)
        else $error("lock held across core reconfiguration");

    property p_pfd_off_no_lock;
        @(posedge clk_i) disable iff (rst_i)
        !ctrl_ff[CTRL_PFD_EN_BIT] [*2] |=> !lock_raw;
    endproperty
    a_pfd_off_no_lock: assert property (p_pfd_off_no_lock)
        else $error("lock kept with detector off");

    property p_done_clear;
        @(posedge clk_i) disable iff (rst_i)
        $fell(recfg_done_ff) |-> $past(pll_reset);
    endproperty
    a_done_clear: assert property (p_done_clear)
        else $error("done flag cleared without reset");

    property p_active_change;
        @(posedge clk_i) disable iff (rst_i)
        $changed(active_ff) |-> $past(sel_state_ff) == PSR_SEL_WAIT_NEW;
    endproperty
    a_active_change: assert property (p_active_change)
        else $error("active input changed outside switch");

    property p_fall_no_switch;
        @(posedge clk_i) disable iff (rst_i)
        sel_state_ff == PSR_SEL_IDLE && !switch_pulse |=> sel_state_ff == PSR_SEL_IDLE;
    endproperty
    a_fall_no_switch: assert property (p_fall_no_switch)
        else $error("switch started without rising request");

    property p_downstream_hold;
        @(posedge clk_i) disable iff (rst_i)
        !lock_sync_ff |=> downstream_reset_o;
    endproperty
    a_downstream_hold: assert property (p_downstream_hold)
        else $error("downstream released before lock");

endmodule // psr_ctrl

// ---- src/psr_pkg.sv ----
package psr_pkg;

    // ------------------------------------------------------------
    // Register map (Wishbone, byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RECFG = 8'h08;
    localparam logic [7:0] ADDR_LOCKCNT = 8'h0C;

    // CTRL fields
    localparam int CTRL_RESET_BIT = 0;
    localparam int CTRL_SWITCH_BIT = 1;
    localparam int CTRL_PFD_EN_BIT = 2;
    localparam int CTRL_SELF_RST_BIT = 3;
    localparam int CTRL_GATE_LSB = 8;
    localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0004;

    // STATUS fields
    localparam int ST_LOCK_BIT = 4;
    localparam int ST_ACTIVE_BIT = 3;
    localparam int ST_LOSS0_BIT = 2;
    localparam int ST_LOSS1_BIT = 1;
    localparam int ST_RCDONE_BIT = 0;
    localparam int ST_BUSY_BIT = 5;

    // RECFG write fields: 0 = post-scale only, 1 = feedback/pre-divider/phase
    localparam int RC_CORE_BIT = 0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int RESET_PULSE_NS = 10;
    localparam int RESET_PULSE_CYC =
        ((RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
        ((RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int LOCK_CYC_DEF = 64;
    localparam int LOSS_CYC_DEF = 16;
    localparam int NUM_OUTS = 5;
    localparam logic [NUM_OUTS-1:0] GATE_RESET_VAL = 5'h00;

    typedef enum logic [1:0] {
        PSR_SEL_IDLE,
        PSR_SEL_GATE,
        PSR_SEL_WAIT_NEW
    } psr_sel_e;

    typedef struct packed {
        logic lock;
        logic active_secondary;
        logic loss_primary;
        logic loss_secondary;
        logic recfg_done;
    } psr_status_s;

endpackage

// ---- sim/psr_ref_model.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// Reference clock sources
// ------------------------------------------------------------
module psr_ref_model #(
    parameter int HALF0_NS = 80,
    parameter int HALF1_NS = 88
) (
    input wire logic run_primary_i,
    input wire logic run_secondary_i,
    output logic primary_reference_clock_o,
    output logic secondary_reference_clock_o
);
    // Within ten percent of each other so loss flags stay meaningful
    // Two free dedicated sources, no on-chip oscillator, no cascade feedback
    // A stopped source freezes at its level, as a dead oscillator would
    initial begin
        primary_reference_clock_o = 1'b0;
        forever begin
            #(HALF0_NS);
            if (run_primary_i) begin
                primary_reference_clock_o = ~primary_reference_clock_o;
            end
        end
    end
    initial begin
        secondary_reference_clock_o = 1'b0;
        forever begin
            #(HALF1_NS);
            if (run_secondary_i) begin
                secondary_reference_clock_o = ~secondary_reference_clock_o;
            end
        end
    end
endmodule // psr_ref_model

// ---- sim/pll_switchover_reset_control_tb_top.sv ----
`timescale 1ns/10ps
module pll_switchover_reset_control_tb_top;
    import psr_pkg::*;
    localparam int S_LOCK = 4;
    localparam int S_ACT = 3;
    localparam int S_LOSS1 = 1;
    localparam int S_DONE = 0;
    localparam int TIMEOUT_CYC = 20000;
    localparam int LOCK_SIM = 8;
    logic clk_i;
    logic rst_i;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic wb_err_o;
    logic ref0;
    logic ref1;
    logic run0;
    logic run1;
    logic [NUM_OUTS-1:0] gates;
    logic pfd_en;
    logic ds_rst;
    psr_status_s status_o;
    logic [31:0] rd;
    logic err;
    int fail_count;
    int check_count;
    int cyc_count;

    psr_ctrl #(.LOCK_CYC(LOCK_SIM), .LOSS_CYC(16)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .primary_reference_clock_i(ref0), .secondary_reference_clock_i(ref1),
        .out_clk_enable_o(gates), .phase_frequency_detector_en_o(pfd_en),
        .downstream_reset_o(ds_rst), .status_o(status_o)
    );
    psr_ref_model REF (
        .run_primary_i(run0), .run_secondary_i(run1),
        .primary_reference_clock_o(ref0), .secondary_reference_clock_o(ref1)
    );

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == TIMEOUT_CYC) begin
            fail_count = fail_count + 1;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Request held until ack or err is seen at a rising edge; data taken and released there
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'hF;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 40);
        chk({31'h0, wb_ack_o | wb_err_o}, 32'h1);
        rd = wb_dat_o;
        err = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wctl(input logic [31:0] d);
        wb(1'b1, ADDR_CTRL, d);
    endtask

    task automatic wait_st(input int b, input logic v, input int lim);
        int n;
        n = 0;
        while (status_o[b] !== v && n < lim) begin
            @(negedge clk_i);
            n++;
        end
        chk({31'h0, status_o[b]}, {31'h0, v});
    endtask

    // Pulse the PLL reset and wait for relock
    task automatic pll_pulse();
        wctl(32'h0000_1F05);
        repeat (2) @(negedge clk_i);
        chk({27'h0, gates}, 32'h0);
        chk({31'h0, status_o.lock}, 32'h0);
        chk({31'h0, status_o.recfg_done}, 32'h0);
        wctl(32'h0000_1F04);
        wait_st(S_LOCK, 1'b1, 400);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_lock();
        wctl(32'h0000_1F04);
        wait_st(S_LOCK, 1'b1, 400);
        repeat (4) @(negedge clk_i);
        chk({31'h0, ds_rst}, 32'h0);
        chk({27'h0, gates}, 32'h1F);
        wb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd & 32'h3F, 32'h10);
    endtask

    task automatic t_recfg();
        wb(1'b1, ADDR_RECFG, 32'h0);
        repeat (20) @(negedge clk_i);
        chk({31'h0, status_o.lock}, 32'h1);
        chk({31'h0, status_o.recfg_done}, 32'h1);
        wb(1'b1, ADDR_RECFG, 32'h1);
        wait_st(S_LOCK, 1'b0, 20);
        wb(1'b0, ADDR_RECFG, 32'h0);
        chk(rd, 32'h0);
        pll_pulse();
    endtask

    // Detector off with outputs gated until lock is back
    task automatic t_pfd();
        wctl(32'h0000_0000);
        wait_st(S_LOCK, 1'b0, 50);
        chk({31'h0, pfd_en}, 32'h0);
        wctl(32'h0000_0004);
        wait_st(S_LOCK, 1'b1, 400);
        chk({27'h0, gates}, 32'h0);
        wctl(32'h0000_1F04);
        @(negedge clk_i);
        chk({27'h0, gates}, 32'h1F);
    endtask

    // Gates down, source switched, gates back after settling
    task automatic t_switch();
        wctl(32'h0000_0004);
        wctl(32'h0000_0006);
        wait_st(S_ACT, 1'b1, 300);
        repeat (40) @(negedge clk_i);
        wctl(32'h0000_1F04);
        repeat (100) @(negedge clk_i);
        chk({31'h0, status_o.active_secondary}, 32'h1);
        pll_pulse();
    endtask

    // Secondary stopped: stuck as source (cur=1) or as target (cur=0)
    task automatic t_stuck(input logic cur);
        @(posedge clk_i);
        run1 <= 1'b0;
        wctl(32'h0000_1F06);
        repeat (150) @(negedge clk_i);
        chk({31'h0, status_o.active_secondary}, {31'h0, cur});
        chk({31'h0, status_o.loss_secondary}, 32'h1);
        wb(1'b0, ADDR_STATUS, 32'h0);
        chk({31'h0, rd[5]}, 32'h1);
        @(posedge clk_i);
        run1 <= 1'b1;
        wait_st(S_ACT, ~cur, 400);
        wctl(32'h0000_1F04);
    endtask

    // Self-reset on lost lock clears the done flag; primary stopped meanwhile
    task automatic t_self();
        @(posedge clk_i);
        run0 <= 1'b0;
        wctl(32'h0000_1F0C);
        wait_st(S_LOCK, 1'b1, 400);
        repeat (30) @(negedge clk_i);
        chk({31'h0, status_o.loss_primary}, 32'h1);
        wb(1'b0, ADDR_LOCKCNT, 32'h0);
        chk(rd, 32'(LOCK_SIM));
        wb(1'b1, ADDR_RECFG, 32'h0);
        wctl(32'h0000_1F08);
        repeat (4) @(negedge clk_i);
        chk({31'h0, status_o.recfg_done}, 32'h0);
        chk({31'h0, status_o.lock}, 32'h0);
        @(posedge clk_i);
        run0 <= 1'b1;
        wctl(32'h0000_1F04);
        wait_st(S_LOCK, 1'b1, 400);
        chk({31'h0, status_o.loss_primary}, 32'h0);
    endtask

    initial begin
        fail_count = 0;
        check_count = 0;
        cyc_count = 0;
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        run0 = 1'b1;
        run1 = 1'b1;
        repeat (16) @(posedge clk_i);
        chk({27'h0, gates}, 32'h0);
        chk({31'h0, ds_rst}, 32'h1);
        chk({27'h0, status_o}, 32'h0);
        rst_i <= 1'b0;
        wb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, CTRL_RESET_VAL);
        chk({31'h0, pfd_en}, 32'h1);
        t_lock();
        t_recfg();
        t_pfd();
        t_switch();
        t_stuck(1'b1);
        t_stuck(1'b0);
        t_self();
        wb(1'b0, 8'h10, 32'h0);
        chk({31'h0, err}, 32'h1);
        end_sim();
    end
endmodule // pll_switchover_reset_control_tb_top
